// [core/ebr_ctrl.sv]
// External bus cycle sequencer with handshake-controlled access phase.
// Assumes the requester holds the cycle parameters stable while busy is high,
// and the outside module clocks its handshake off bus_reference_clock.
//
// Overview of operation
// - Software picks which level of the handshake input means ready.
// - Synchronous handshake gives the shortest cycle; the outside module drives it on our clock.
// - Asynchronous handshake passes an extra sync stage and costs at least one wait state.
// - The first sample point of a cycle follows from that cycle's programmed phase lengths.
// - A handshake sampled inactive inserts one wait state and is sampled again.
// - A handshake sampled active ends the access phase; the hold phase follows.
// - Asynchronous mode skips the sample at the end of the access phase and uses a pin level two clocks older than synchronous mode.
// - The handshake is ignored until the mandatory access wait states are over.
// - Read data is captured on the edge that raises the read strobe; the address holds until the next cycle starts.
// - An address change after the read strobe ends does not disturb captured data.
// - Each cycle runs address setup, command delay, data setup, access and hold phases.
`timescale 1ns/1ns
`default_nettype none
module ebr_ctrl
    import ebr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 cyc_req,
    input  wire logic                 cyc_write,
    input  wire logic [ADDR_W-1:0]    cyc_addr,
    input  wire logic [DATA_W-1:0]    cyc_wdata,
    input  wire logic [CNT_W-1:0]     len_ab,
    input  wire logic [CNT_W-1:0]     len_c,
    input  wire logic [CNT_W-1:0]     len_d,
    input  wire logic [CNT_W-1:0]     access_phase_length,
    input  wire logic [CNT_W-1:0]     len_f,
    input  wire logic                 ready_enable,
    input  wire logic                 ready_active_high,
    input  wire logic                 ready_async,
    input  wire logic                 ready_pin,
    input  wire logic [DATA_W-1:0]    data_pin_in,
    output logic                      bus_reference_clock,
    output logic [ADDR_W-1:0]         addr_pin,
    output logic [DATA_W-1:0]         data_pin_out,
    output logic                      data_pin_oe,
    output logic                      rd_b,
    output logic                      wr_b,
    output logic                      busy,
    output logic                      cyc_done,
    output logic [DATA_W-1:0]         cyc_rdata
);
    ////////////////////////////////////////////////////////////////////////
    // Handshake input conditioning
    logic ready_sync_lvl;
    logic ready_cap;
    logic ready_async_lvl;
    logic ready_seen;

    // Asynchronous path: two-flop synchroniser
    ebr_sync u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (ready_pin),
        .dout  (ready_sync_lvl)
    );

    // Synchronous path: single capture, pin is already on our clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_cap       <= 1'b0;
            ready_async_lvl <= 1'b0;
        end else begin
            ready_cap       <= ready_pin;
            ready_async_lvl <= ready_sync_lvl;      // Extra stage
        end
    end

    // Polarity and mode select of the sampled level
    always_comb begin
        if (ready_async) begin
            ready_seen = ready_async_lvl ~^ ready_active_high;
        end else begin
            ready_seen = ready_cap ~^ ready_active_high;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus clock divider: one unit is two system clocks
    logic ref_clk;
    logic next_ref_clk;
    logic unit_end;

    always_comb begin
        next_ref_clk = ~ref_clk;
        unit_end     = ref_clk;    // Unit ends when the reference clock falls back
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_clk <= 1'b0;
        end else begin
            ref_clk <= next_ref_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    ebr_phase_t        phase, next_phase;
    logic [CNT_W-1:0]  cnt, next_cnt;
    logic              is_write, next_is_write;
    logic [ADDR_W-1:0] next_addr_pin;
    logic [DATA_W-1:0] next_data_pin_out;
    logic              next_data_pin_oe;
    logic              next_rd_b;
    logic              next_wr_b;
    logic              next_busy;
    logic              next_cyc_done;
    logic [DATA_W-1:0] next_cyc_rdata;
    logic              last_unit;
    logic              end_access;

    // Shared end-of-access action: raise strobes, capture read data
    always_comb begin
        last_unit = unit_end && (cnt <= 6'h01);
        end_access = 1'b0;
        next_phase        = phase;
        next_cnt          = cnt;
        next_is_write     = is_write;
        next_addr_pin     = addr_pin;
        next_data_pin_out = data_pin_out;
        next_data_pin_oe  = data_pin_oe;
        next_rd_b         = rd_b;
        next_wr_b         = wr_b;
        next_busy         = busy;
        next_cyc_done     = 1'b0;
        next_cyc_rdata    = cyc_rdata;
        if (unit_end && cnt != CNT_RST) begin
            next_cnt = cnt - 6'h01;
        end
        case (phase)
            EBR_IDLE: begin
                if (cyc_req && unit_end) begin
                    next_phase        = EBR_AB;
                    next_cnt          = (len_ab < AB_MIN) ? AB_MIN :
                                        (len_ab > AB_MAX) ? AB_MAX : len_ab;
                    next_is_write     = cyc_write;
                    next_addr_pin     = cyc_addr;
                    next_data_pin_out = cyc_wdata;
                    next_busy         = 1'b1;
                end
            end
            EBR_AB: begin
                if (last_unit) begin
                    next_phase = EBR_C;
                    next_cnt   = (len_c > C_MAX) ? C_MAX : len_c;
                end
            end
            EBR_C: begin
                // A zero length still waits out one unit, a length n takes n units, at most C_MAX
                if (last_unit) begin
                    next_phase       = EBR_D;
                    next_cnt         = (len_d > D_MAX) ? D_MAX : len_d;
                    next_data_pin_oe = is_write;
                end
            end
            EBR_D: begin
                if (last_unit) begin
                    next_phase = EBR_E;
                    next_cnt   = (access_phase_length < E_MIN) ? E_MIN :
                                 (access_phase_length > E_MAX) ? E_MAX :
                                 access_phase_length;
                    next_rd_b  = is_write;
                    next_wr_b  = ~is_write;
                end
            end
            EBR_E: begin
                // Handshake is not looked at before the mandatory units end
                if (last_unit) begin
                    if (!ready_enable) begin
                        end_access = 1'b1;
                    end else if (ready_async) begin
                        next_phase      = EBR_WAIT;
                    end else if (ready_seen) begin
                        end_access = 1'b1;
                    end else begin
                        next_phase = EBR_WAIT;
                    end
                end
            end
            EBR_WAIT: begin
                // One handshake wait state per inactive sample
                if (unit_end) begin
                    if (ready_seen) begin
                        end_access = 1'b1;
                    end
                end
            end
            EBR_F: begin
                if (last_unit) begin
                    next_phase       = EBR_IDLE;
                    next_busy        = 1'b0;
                    next_cyc_done    = 1'b1;
                    next_data_pin_oe = 1'b0;
                end
            end
            default: begin
                next_phase = EBR_IDLE;
            end
        endcase
        if (end_access) begin
            next_phase = EBR_F;
            next_cnt   = (len_f > F_MAX) ? F_MAX : len_f;
            next_rd_b  = 1'b1;
            next_wr_b  = 1'b1;
            if (!is_write) begin
                next_cyc_rdata = data_pin_in;
            end
        end
    end

    // Register the sequencer state and pin drivers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase        <= EBR_IDLE;
            cnt          <= CNT_RST;
            is_write     <= 1'b0;
            addr_pin     <= ADDR_RST;
            data_pin_out <= DATA_RST;
            data_pin_oe  <= 1'b0;
            rd_b         <= 1'b1;
            wr_b         <= 1'b1;
            busy         <= 1'b0;
            cyc_done     <= 1'b0;
            cyc_rdata    <= DATA_RST;
        end else begin
            phase        <= next_phase;
            cnt          <= next_cnt;
            is_write     <= next_is_write;
            addr_pin     <= next_addr_pin;
            data_pin_out <= next_data_pin_out;
            data_pin_oe  <= next_data_pin_oe;
            rd_b         <= next_rd_b;
            wr_b         <= next_wr_b;
            busy         <= next_busy;
            cyc_done     <= next_cyc_done;
            cyc_rdata    <= next_cyc_rdata;
        end
    end

    assign bus_reference_clock = ref_clk;
endmodule
`default_nettype wire

// [core/ebr_pkg.sv]
// Constants, phase limits and state type of the bus-cycle handshake block.
// Assumes one system clock; the bus clock unit is two system clocks.
package ebr_pkg;
    // Field widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 6;
    // Phase length limits in bus clock units
    localparam logic [CNT_W-1:0] AB_MIN = 6'h01;
    localparam logic [CNT_W-1:0] AB_MAX = 6'h02;
    localparam logic [CNT_W-1:0] C_MAX  = 6'h03;
    localparam logic [CNT_W-1:0] D_MAX  = 6'h01;
    localparam logic [CNT_W-1:0] E_MIN  = 6'h01;
    localparam logic [CNT_W-1:0] E_MAX  = 6'h20;
    localparam logic [CNT_W-1:0] F_MAX  = 6'h03;
    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RST  = 6'h00;
    // Sync stages in front of the asynchronous handshake
    localparam int SYNC_STAGES = 2;
    // Cycle phases
    typedef enum logic [2:0] {
        EBR_IDLE, EBR_AB, EBR_C, EBR_D, EBR_E, EBR_WAIT, EBR_F
    } ebr_phase_t;
endpackage

// [core/ebr_sync.sv]
// Two-flop synchroniser for one level coming from a pin.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ns
`default_nettype none
module ebr_sync
    import ebr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);
    logic [SYNC_STAGES-1:0] stage;
    logic [SYNC_STAGES-1:0] next_stage;

    ////////////////////////////////////////////////////////////////////////
    // Shift the level through the stages
    always_comb begin
        next_stage = {stage[SYNC_STAGES-2:0], din};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage <= '0;
        end else begin
            stage <= next_stage;
        end
    end

    assign dout = stage[SYNC_STAGES-1];
endmodule
`default_nettype wire

// [test/ebr_asserts.sv]
// Concurrent checks on the ports of the bus-cycle sequencer.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ebr_chk
    import ebr_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic [CNT_W-1:0]  access_phase_length,
    input wire logic              ready_enable,
    input wire logic              ready_active_high,
    input wire logic              ready_async,
    input wire logic              ready_pin,
    input wire logic [DATA_W-1:0] data_pin_in,
    input wire logic              bus_reference_clock,
    input wire logic [ADDR_W-1:0] addr_pin,
    input wire logic              rd_b,
    input wire logic              wr_b,
    input wire logic              busy,
    input wire logic              cyc_done,
    input wire logic [DATA_W-1:0] cyc_rdata
);
    logic [7:0] low_cnt;
    logic [7:0] next_low_cnt;
    logic [6:0] acc2;
    ////////////////////////////////////////////////////////////////////////////////
    // Length of the current read strobe in clocks
    always_comb begin
        next_low_cnt = rd_b ? 8'h00 : low_cnt + 8'h01;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end
    assign acc2 = {access_phase_length, 1'h0};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    // Cycle framing and strobes
    idle_strobe_a: assert property (!busy |-> rd_b && wr_b)
        else $error("strobe low outside a cycle");
    done_pulse_a: assert property (cyc_done |-> !busy ##1 !cyc_done)
        else $error("cycle end pulse wrong");
    ref_clock_a: assert property (1'h1 |=> $changed(bus_reference_clock))
        else $error("reference clock did not toggle");
    addr_hold_a: assert property (busy && $past(busy) |-> $stable(addr_pin))
        else $error("address moved inside a cycle");
    // Read data capture on the strobe's rising edge
    rd_capture_a: assert property (
        $rose(rd_b) |-> cyc_rdata == $past(data_pin_in))
        else $error("read data not taken at strobe end");
    rd_hold_a: assert property (!$rose(rd_b) |-> $stable(cyc_rdata))
        else $error("read data changed without a read");
    // Handshake sampling and wait states
    sync_grant_a: assert property (
        $rose(rd_b) && ready_enable && !ready_async
        |-> $past(ready_pin, 2) == ready_active_high)
        else $error("cycle ended without ready");
    sync_len_a: assert property (
        $rose(rd_b) && ready_enable && !ready_async |-> low_cnt >= acc2)
        else $error("access phase cut short");
    async_len_a: assert property (
        $rose(rd_b) && ready_enable && ready_async |-> low_cnt >= acc2 + 7'h02)
        else $error("asynchronous ready without wait state");
    plain_len_a: assert property (
        $rose(rd_b) && !ready_enable |-> low_cnt == acc2)
        else $error("access length wrong");
endmodule
bind ebr_ctrl ebr_chk u_chk (.clk, .rst_b, .access_phase_length, .ready_enable,
    .ready_active_high, .ready_async, .ready_pin, .data_pin_in, .bus_reference_clock,
    .addr_pin, .rd_b, .wr_b, .busy, .cyc_done, .cyc_rdata);
`default_nettype wire

// [test/ebr_partner.sv]
// Model of the outside memory answering the bus with ready and read data.
// Assumes it is clocked by the same system clock as the sequencer.
`timescale 1ns/1ns
`default_nettype none
module ebr_partner
    import ebr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              rd_b,
    input  wire logic              wr_b,
    input  wire logic [ADDR_W-1:0] addr_pin,
    input  wire logic              act_high,
    input  wire logic [7:0]        wait_clks,
    output logic                   ready_pin,
    output logic [DATA_W-1:0]      data_pin_in
);
    logic [7:0] low_cnt;
    logic       strobe;
    logic       ready_lvl;
    assign strobe = !rd_b || !wr_b;
    // Clocks the command strobe has been low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= strobe ? low_cnt + 8'h01 : 8'h00;
        end
    end
    // Ready after the delay, on our clock, dropped as soon as the strobe rises
    assign ready_lvl = strobe && low_cnt >= wait_clks;
    assign ready_pin = ready_lvl ? act_high : !act_high;
    // Data from the address; turned over right after the read strobe rises
    assign data_pin_in = {DATA_W{rd_b}} ^ addr_pin[DATA_W-1:0] ^ 16'hA5A5;
endmodule
`default_nettype wire

// [test/test_ext_bus_ready_handshake.sv]
// Testbench for the bus-cycle sequencer with its outside memory model.
// Assumes ebr_ctrl, ebr_partner and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_ext_bus_ready_handshake;
    import ebr_pkg::*;
    logic              clk, rst_b, cyc_req, cyc_write, ready_pin, ready_enable;
    logic              ready_active_high, ready_async, bus_reference_clock;
    logic              data_pin_oe, rd_b, wr_b, busy, cyc_done;
    logic [ADDR_W-1:0] cyc_addr, addr_pin;
    logic [DATA_W-1:0] cyc_wdata, data_pin_in, data_pin_out, cyc_rdata;
    logic [CNT_W-1:0]  len_ab, len_c, len_d, len_e, len_f;
    logic [7:0]        wait_clks;
    int                num_errors, tests_run, n;
    ebr_ctrl u_dut (.clk, .rst_b, .cyc_req, .cyc_write, .cyc_addr, .cyc_wdata, .len_ab,
        .len_c, .len_d, .access_phase_length(len_e), .len_f, .ready_enable,
        .ready_active_high, .ready_async, .ready_pin, .data_pin_in, .bus_reference_clock,
        .addr_pin, .data_pin_out, .data_pin_oe, .rd_b, .wr_b, .busy, .cyc_done, .cyc_rdata);
    ebr_partner u_far (.clk, .rst_b, .rd_b, .wr_b, .addr_pin, .act_high(ready_active_high),
        .wait_clks, .ready_pin, .data_pin_in);
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Clocks from take to end for given phase units and ready wait units
    function automatic int base(input int ab, c, d, e, f, u);
        return 2 * (ab + (c > 0 ? c : 1) + (d > 0 ? d : 1) + e + u + (f > 0 ? f : 1));
    endfunction
    // One bus cycle; n counts clocks from take to the end pulse
    task automatic run(input logic wr, input logic [5:0] ab, c, d, e, f,
                       input logic en, hi, as, input logic [7:0] w, input logic [23:0] a);
        int i;
        {cyc_write, cyc_addr, cyc_wdata} = {wr, a, ~a[15:0]};
        {len_ab, len_c, len_d, len_e, len_f} = {ab, c, d, e, f};
        {ready_enable, ready_active_high, ready_async, wait_clks} = {en, hi, as, w};
        cyc_req = 1'h1;
        for (i = 0; i < 8 && busy !== 1'h1; i++) @(negedge clk);
        cyc_req = 1'h0;
        for (n = 0; n < 300 && cyc_done !== 1'h1; n++) begin
            @(negedge clk);
            if (wr_b === 1'h0) begin
                chk("wdata", {data_pin_oe, data_pin_out}, {1'h1, ~a[15:0]});
            end
            if (rd_b === 1'h0) begin
                chk("rd_oe", data_pin_oe, 1'h0);
            end
            if (rd_b === 1'h0 || wr_b === 1'h0) begin
                chk("addr", addr_pin, a);
            end
        end
        if (n == 300 || i == 8) begin
            num_errors++;
            give_verdict();
        end
        if (!wr) chk("rdata", cyc_rdata, a[15:0] ^ 16'hA5A5);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Shortest synchronous read, then longest setup, delay and hold phases with a short access phase
    task automatic sc_sync();
        run(0, 1, 0, 0, 1, 0, 1, 1, 0, 0, 24'h3A1234);
        chk("sync_len", n, base(1, 0, 0, 1, 0, 0));
        run(0, 2, 3, 1, 4, 3, 1, 1, 0, 0, 24'h81BEEF);
        chk("phase_len", n, base(2, 3, 1, 4, 3, 0));
    endtask
    // Low level means ready
    task automatic sc_polarity();
        run(0, 1, 0, 0, 1, 0, 1, 0, 0, 0, 24'h5C5A5A);
        chk("low_ready_len", n, base(1, 0, 0, 1, 0, 0));
    endtask
    // Late ready adds wait units; early ready waits out the access phase
    task automatic sc_wait();
        run(0, 1, 0, 0, 2, 0, 1, 1, 0, 5, 24'h7E0F0F);
        chk("wait_len", n, base(1, 0, 0, 2, 0, 2));
        run(0, 1, 0, 0, 3, 0, 1, 1, 0, 0, 24'h123C3C);
        chk("mand_len", n, base(1, 0, 0, 3, 0, 0));
    endtask
    // Asynchronous ready costs at least one wait unit
    task automatic sc_async();
        run(0, 1, 0, 0, 1, 0, 1, 1, 1, 0, 24'hC3C3C3);
        chk("async_len", n >= base(1, 0, 0, 1, 0, 1), 1'h1);
    endtask
    // Handshake off with a silent memory, longest access phase
    task automatic sc_off();
        run(0, 1, 0, 0, 32, 0, 0, 1, 0, 200, 24'h447777);
        chk("off_len", n, base(1, 0, 0, 32, 0, 0));
    endtask
    // Write cycle with the address setup, delay, access and hold phases stretched; data setup stays at one unit
    task automatic sc_write();
        run(1, 2, 3, 1, 2, 3, 1, 1, 0, 0, 24'hFFABCD);
        chk("write_len", n, base(2, 3, 1, 2, 3, 0));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reset, then the scenarios in turn
    initial begin
        {clk, rst_b, cyc_req, cyc_write, cyc_addr, cyc_wdata} = '0;
        {len_ab, len_c, len_d, len_e, len_f} = {6'h01, 6'h00, 6'h00, 6'h01, 6'h00};
        {ready_enable, ready_active_high, ready_async, wait_clks} = {3'h2, 8'h00};
        {num_errors, tests_run, n} = '0;
        repeat (2) @(negedge clk);
        rst_b = 1'h1;
        sc_sync();
        sc_polarity();
        sc_wait();
        sc_async();
        sc_off();
        sc_write();
        give_verdict();
    end
endmodule
`default_nettype wire
